// ==== lml_maint_ctrl.sv ====
/*
  Maintenance and loopback control for a multi-line communications
  multiplexer: sync line control, async loopback and scanner maintenance.
  Assumes all inputs except line_rx_pin come from logic on ref_clk;
  line select is held by an outside register.

*/
// Chosen here: the strobed register port and the placing of the registers.
module lml_maint_ctrl #(
  parameter int NUM_LINES = 16,
  parameter int STATUS_W  = 4
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  input  wire logic                            ce,
  input  wire logic [lml_pkg::ADDR_W-1:0]      addr,
  input  wire logic [lml_pkg::DATA_W-1:0]      wdata,
  input  wire logic                            wr_stb,
  input  wire logic                            rd_stb,
  output logic      [lml_pkg::DATA_W-1:0]      rdata,
  output logic                                 irq,
  input  wire logic                            sys_init,
  input  wire logic                            branch_a_taken,
  input  wire logic                            branch_b_taken,
  input  wire logic [lml_pkg::SEL_W-1:0]       line_select,
  input  wire logic [NUM_LINES-1:0]            line_tx_out,
  input  wire logic [NUM_LINES-1:0]            line_rx_pin,
  input  wire logic [NUM_LINES-1:0]            modem_enabled,
  input  wire logic [NUM_LINES*STATUS_W-1:0]   modem_status_in,
  input  wire logic [NUM_LINES-1:0]            status_transition,
  output logic      [NUM_LINES*STATUS_W-1:0]   modem_status_out,
  output logic      [NUM_LINES-1:0]            receiver_in,
  output logic      [NUM_LINES-1:0]            tx_line_enable,
  output logic      [NUM_LINES-1:0]            rx_line_enable,
  output logic      [NUM_LINES-1:0]            dsb_remote_enable,
  output logic      [NUM_LINES-1:0]            maint_clk_pulse,
  output logic      [NUM_LINES-1:0]            line_aux_bit,
  output logic      [2*NUM_LINES-1:0]          line_mode
);
  import lml_pkg::*;

  localparam int NUM_GRP = NUM_LINES / 4;

  // Elaboration checks: group decode needs whole groups of four lines
  // inside the 4-bit select, so counts that are not a multiple of four would alias groups
  if (NUM_LINES < 4 || NUM_LINES > 16 || (NUM_LINES % 4) != 0) begin : g_bad_lines
    $error("NUM_LINES must be 4, 8, 12 or 16");
  end
  if (STATUS_W < 1) begin : g_bad_status
    $error("STATUS_W must be at least 1");
  end

  function automatic logic [1:0] group_of(input logic [SEL_W-1:0] line);
    group_of = line[3:2];
  endfunction

  function automatic logic is_int_mode(input logic [1:0] mode);
    is_int_mode = (mode == MODE_INT);
  endfunction

  // Group state
  logic [NUM_GRP-1:0][1:0] mode_reg,  mode_next;
  logic [NUM_GRP-1:0]      txdis_reg, txdis_next;
  logic [NUM_GRP-1:0]      mdata_reg, mdata_next;
  // Per line state
  logic [NUM_LINES-1:0]    aux_reg,   aux_next;
  logic [NUM_LINES-1:0]    aint_reg,  aint_next;
  logic [NUM_LINES-1:0]    rx_meta_reg;
  logic [NUM_LINES-1:0]    rx_sync_reg;
  logic [NUM_LINES-1:0]    recv_reg,  recv_next;
  logic [NUM_LINES-1:0]    txen_reg,  txen_next;
  logic [NUM_LINES-1:0]    rxen_reg,  rxen_next;
  logic [NUM_LINES-1:0]    mclk_reg,  mclk_next;
  logic [NUM_LINES*STATUS_W-1:0] mstat_reg, mstat_next;
  // Register file state
  logic [1:0]              branch_reg,  branch_next;
  logic [1:0]              asel_reg,    asel_next;
  logic [SEL_W-1:0]        scan_line_reg, scan_line_next;
  logic                    done_reg,    done_next;
  logic                    force_reg,   force_next;
  lml_scan_t               scan_reg,    scan_next;
  logic [STEP_CNT_W-1:0]   step_cnt_reg, step_cnt_next;
  logic [IRQ_W-1:0]        irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0]        irq_mask_reg, irq_mask_next;
  logic [DATA_W-1:0]       rdata_reg,   rdata_next;

  logic                    sel_ok;
  logic [1:0]              sel_grp;
  logic                    window_bit;
  logic                    wr_sync;
  logic                    wr_async;
  logic                    wr_csr;
  logic [IRQ_W-1:0]        irq_evt;
  logic [SEL_W-1:0]        step_line;

  assign sel_ok  = ({28'h0000000, line_select} < NUM_LINES);
  assign sel_grp = group_of(line_select);
  assign wr_sync  = wr_stb && (addr == ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
  assign wr_async = wr_stb && (addr == ADDR_LINE_CONTROL_ASYNC_MAINTENANCE);
  assign wr_csr   = wr_stb && (addr == ADDR_SCAN_CSR);
  assign step_line = scan_line_reg + 4'h1;

  // Observation window on the selected line's input
  always_comb begin
    window_bit = 1'b0;
    if (sel_ok) begin
      if (!txdis_reg[sel_grp]) begin
        window_bit = line_tx_out[line_select];
      end else if (is_int_mode(mode_reg[sel_grp])) begin
        window_bit = mdata_reg[sel_grp];
      end else begin
        window_bit = rx_sync_reg[line_select];
      end
    end
  end

  // Line control: group and per-line storage
  always_comb begin
    mode_next  = mode_reg;
    txdis_next = txdis_reg;
    mdata_next = mdata_reg;
    aux_next   = aux_reg;
    aint_next  = aint_reg;
    asel_next  = asel_reg;
    mclk_next  = '0;
    if (sys_init) begin
      mode_next  = '0;
      txdis_next = '0;
      mdata_next = '0;
      asel_next  = '0;
      aint_next  = '0;
    end else begin
      if (wr_sync && wdata[LCR_STROBE] && sel_ok) begin
        mode_next[sel_grp]  = wdata[LCR_MODE_LO +: 2];
        txdis_next[sel_grp] = wdata[LCR_TXDIS];
        mdata_next[sel_grp] = wdata[LCR_MDATA];
        aux_next[line_select] = wdata[LCR_LINE_BIT];
      end
      if (wr_sync && wdata[LCR_MCLK]) begin
        // one bit per mode 01 line
        for (int i = 0; i < NUM_LINES; i++) begin
          mclk_next[i] = is_int_mode(mode_reg[i/4]);
        end
      end
      if (wr_async) begin
        asel_next = wdata[ALCR_SEL_LO +: 2];
        if (wdata[LCR_STROBE] && sel_ok && wdata[ALCR_SEL_LO +: 2] == ALCR_SEL_MAINT) begin
          aint_next[line_select] = wdata[ALCR_INT];
        end
      end
    end
  end

  // Line path outputs, registered
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      recv_next[i] = rx_sync_reg[i];
      txen_next[i] = !txdis_reg[i/4];
      rxen_next[i] = 1'b1;
      if (aint_reg[i]) begin
        recv_next[i] = line_tx_out[i];
        txen_next[i] = 1'b0;
        rxen_next[i] = 1'b0;
      end else if (is_int_mode(mode_reg[i/4])) begin
        recv_next[i] = txdis_reg[i/4] ? mdata_reg[i/4] : line_tx_out[i];
      end
    end
    for (int i = 0; i < NUM_LINES; i++) begin
      mstat_next[i*STATUS_W +: STATUS_W] = modem_status_in[i*STATUS_W +: STATUS_W]
        | {STATUS_W{force_reg && modem_enabled[i]}};
    end
  end

  // Scanner step machine, branch flags, interrupts and read port
  always_comb begin
    scan_next      = scan_reg;
    step_cnt_next  = step_cnt_reg;
    scan_line_next = scan_line_reg;
    done_next      = done_reg;
    force_next     = force_reg;
    irq_evt        = '0;
    irq_mask_next  = irq_mask_reg;
    rdata_next     = '0;
    branch_next[0] = !branch_a_taken;
    branch_next[1] = !branch_b_taken;

    case (scan_reg)
      SCAN_IDLE: begin
        if (wr_csr && wdata[CSR_STEP] && !sys_init) begin
          scan_next     = SCAN_STEP;
          step_cnt_next = STEP_CNT_W'(STEP_CYCLES - 1);
        end
      end
      SCAN_STEP: begin
        if (sys_init) begin
          scan_next = SCAN_IDLE;
        end else if (step_cnt_reg == '0) begin
          scan_next      = SCAN_IDLE;
          scan_line_next = step_line;
          irq_evt[IRQ_STEP_END] = 1'b1;
          if ({28'h0000000, step_line} < NUM_LINES && status_transition[step_line]) begin
            done_next = 1'b1;
            irq_evt[IRQ_DONE] = 1'b1;
          end
        end else begin
          step_cnt_next = step_cnt_reg - 6'h01;
        end
      end
      default: begin
        scan_next = SCAN_IDLE;
      end
    endcase

    if (wr_csr) begin
      force_next = wdata[CSR_FORCE];
    end
    if (sys_init || (wr_csr && wdata[CSR_CLRSCAN])) begin
      force_next     = 1'b0;
      scan_line_next = '0;
      if (!irq_evt[IRQ_DONE]) begin
        done_next = 1'b0;
      end
    end

    irq_evt[IRQ_SYNC_STROBE]  = wr_sync && wdata[LCR_STROBE] && !sys_init;
    irq_evt[IRQ_ASYNC_STROBE] = wr_async && wdata[LCR_STROBE] && !sys_init;
    if (wr_stb && addr == ADDR_IRQ_MASK) begin
      irq_mask_next = wdata[IRQ_W-1:0];
    end
    // Read clears, but an event in the same cycle survives
    irq_stat_next = irq_stat_reg | irq_evt;
    if (rd_stb && addr == ADDR_IRQ_STATUS) begin
      irq_stat_next = irq_evt;
    end

    if (rd_stb) begin
      case (addr)
        ADDR_LINE_CONTROL_SYNC_MAINTENANCE: begin
          rdata_next[LCR_BRANCH_B:LCR_BRANCH_A] = branch_reg;
          rdata_next[LCR_WINDOW] = window_bit;
        end
        ADDR_LINE_CONTROL_ASYNC_MAINTENANCE: begin
          rdata_next[LCR_BRANCH_B:LCR_BRANCH_A] = branch_reg;
        end
        ADDR_SCAN_CSR: begin
          rdata_next[CSR_LINE_LO +: SEL_W] = scan_line_reg;
          rdata_next[CSR_DONE]  = done_reg;
          rdata_next[CSR_FORCE] = force_reg;
        end
        ADDR_IRQ_STATUS: begin
          rdata_next[IRQ_W-1:0] = irq_stat_reg;
        end
        ADDR_IRQ_MASK: begin
          rdata_next[IRQ_W-1:0] = irq_mask_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg      <= '0;
      txdis_reg     <= '0;
      mdata_reg     <= '0;
      aux_reg       <= '0;
      aint_reg      <= '0;
      asel_reg      <= '0;
      mclk_reg      <= '0;
      rx_meta_reg   <= '0;
      rx_sync_reg   <= '0;
      recv_reg      <= '0;
      txen_reg      <= '0;
      rxen_reg      <= '0;
      mstat_reg     <= '0;
      branch_reg    <= BRANCH_RST;
      scan_reg      <= SCAN_IDLE;
      step_cnt_reg  <= '0;
      scan_line_reg <= '0;
      done_reg      <= 1'b0;
      force_reg     <= 1'b0;
      irq_stat_reg  <= '0;
      irq_mask_reg  <= IRQ_MASK_RST;
      rdata_reg     <= RDATA_RST;
    end else if (ce) begin
      mode_reg      <= mode_next;
      txdis_reg     <= txdis_next;
      mdata_reg     <= mdata_next;
      aux_reg       <= aux_next;
      aint_reg      <= aint_next;
      asel_reg      <= asel_next;
      mclk_reg      <= mclk_next;
      rx_meta_reg   <= line_rx_pin;
      rx_sync_reg   <= rx_meta_reg;
      recv_reg      <= recv_next;
      txen_reg      <= txen_next;
      rxen_reg      <= rxen_next;
      mstat_reg     <= mstat_next;
      branch_reg    <= branch_next;
      scan_reg      <= scan_next;
      step_cnt_reg  <= step_cnt_next;
      scan_line_reg <= scan_line_next;
      done_reg      <= done_next;
      force_reg     <= force_next;
      irq_stat_reg  <= irq_stat_next;
      irq_mask_reg  <= irq_mask_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign rdata             = rdata_reg;
  assign irq               = |(irq_stat_reg & irq_mask_reg);
  assign receiver_in       = recv_reg;
  assign tx_line_enable    = txen_reg;
  assign rx_line_enable    = rxen_reg;
  assign dsb_remote_enable = rxen_reg;
  assign maint_clk_pulse   = mclk_reg;
  assign line_aux_bit      = aux_reg;
  assign modem_status_out  = mstat_reg;

  generate
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_mode
      assign line_mode[2*g +: 2] = mode_reg[g/4];
    end
  endgenerate

endmodule

// ==== lml_pkg.sv ====
/*
  Constants, field positions, timing counts and types for the line
  maintenance and loopback control block.
  Assumes a single 20 MHz clock and a simple strobe register port.
*/
package lml_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int SEL_W  = 4;

  // Register addresses on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_LINE_CONTROL_SYNC_MAINTENANCE   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CONTROL_ASYNC_MAINTENANCE  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_SCAN_CSR   = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 3'h4;

  // Line control register, synchronous card layout
  localparam int LCR_BRANCH_A = 0;
  localparam int LCR_BRANCH_B = 1;
  localparam int LCR_WINDOW   = 7;
  localparam int LCR_MCLK     = 8;
  localparam int LCR_TXDIS    = 9;
  localparam int LCR_MODE_LO  = 11;
  localparam int LCR_LINE_BIT = 13;
  localparam int LCR_MDATA    = 14;
  localparam int LCR_STROBE   = 15;

  // Line control register, asynchronous card layout
  localparam int ALCR_SEL_LO  = 9;
  localparam int ALCR_INT     = 11;
  localparam logic [1:0] ALCR_SEL_MAINT = 2'h3;

  // Scanner control and status register
  localparam int CSR_LINE_LO  = 0;
  localparam int CSR_DONE     = 7;
  localparam int CSR_STEP     = 8;
  localparam int CSR_FORCE    = 9;
  localparam int CSR_CLRSCAN  = 11;

  // Interrupt status and mask layout
  localparam int IRQ_W            = 4;
  localparam int IRQ_STEP_END     = 0;
  localparam int IRQ_DONE         = 1;
  localparam int IRQ_SYNC_STROBE  = 2;
  localparam int IRQ_ASYNC_STROBE = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // Reset values
  localparam logic [1:0]  BRANCH_RST = 2'h3;
  localparam logic [15:0] RDATA_RST  = 16'h0000;

  // Step timing: nominal 1.2 us at the 20 MHz reference clock
  localparam int CLK_HZ       = 20_000_000;
  localparam int STEP_TIME_NS = 1200;
  localparam int STEP_CYCLES_RAW = (STEP_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int STEP_CYCLES  = (STEP_CYCLES_RAW < 1) ? 1 : STEP_CYCLES_RAW;
  localparam int STEP_CNT_W   = 6;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_INT    = 2'b01,
    MODE_EXT    = 2'b10,
    MODE_SYSTST = 2'b11
  } lml_mode_t;

  typedef enum logic {
    SCAN_IDLE = 1'b0,
    SCAN_STEP = 1'b1
  } lml_scan_t;

endpackage

// ==== lml_maint_ctrl_assertions.sv ====
/*
  Port-level checker for the line maintenance and loopback block.
  Assumes ce stays high while checking and one clock domain.
*/
module lml_maint_chk
  import lml_pkg::*;
#(
  parameter int NUM_LINES = 16,
  parameter int STATUS_W  = 4
) (
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic [ADDR_W-1:0]             addr,
  input wire logic [DATA_W-1:0]             wdata,
  input wire logic                          wr_stb,
  input wire logic                          rd_stb,
  input wire logic [DATA_W-1:0]             rdata,
  input wire logic                          sys_init,
  input wire logic                          branch_a_taken,
  input wire logic                          branch_b_taken,
  input wire logic [NUM_LINES*STATUS_W-1:0] modem_status_in,
  input wire logic [NUM_LINES*STATUS_W-1:0] modem_status_out,
  input wire logic [NUM_LINES-1:0]          tx_line_enable,
  input wire logic [NUM_LINES-1:0]          rx_line_enable,
  input wire logic [NUM_LINES-1:0]          maint_clk_pulse,
  input wire logic [NUM_LINES-1:0]          line_aux_bit,
  input wire logic [2*NUM_LINES-1:0]        line_mode
);
  logic sync_wr;
  logic rd_lcr;

  assign sync_wr = wr_stb && (addr == ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
  assign rd_lcr  = rd_stb && (addr == ADDR_LINE_CONTROL_SYNC_MAINTENANCE);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_rdata_idle_zero: assert property (
    !$past(rd_stb) |-> rdata == 16'h0000) else $error("rdata not zero outside a read");
  a_read_resv_zero: assert property (
    $past(rd_stb) |-> (rdata & 16'hFD70) == 16'h0000) else $error("command bit read as one");
  a_unmapped_zero: assert property (
    $past(rd_stb) && $past(addr) > ADDR_IRQ_MASK |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_branch_flags: assert property (
    $past(rd_lcr) |-> rdata[1:0] == {!$past(branch_b_taken, 2), !$past(branch_a_taken, 2)})
    else $error("branch flags wrong");
  a_pulse_cause: assert property (
    |maint_clk_pulse |-> $past(sync_wr) && $past(wdata[LCR_MCLK]))
    else $error("clock pulse without write");
  a_mode_cause: assert property (
    $changed(line_mode) |-> ($past(sync_wr) && $past(wdata[LCR_STROBE])) || $past(sys_init))
    else $error("mode changed without strobe");
  a_aux_cause: assert property (
    $changed(line_aux_bit) |-> $past(sync_wr) && $past(wdata[LCR_STROBE]))
    else $error("line bit changed without strobe");
  a_init_mode: assert property (
    sys_init [*2] |-> line_mode == '0) else $error("initialize left a mode set");
  a_init_force: assert property (
    sys_init [*3] |-> modem_status_out == $past(modem_status_in))
    else $error("status still forced after initialize");
  a_loop_tx_off: assert property (
    (tx_line_enable & ~rx_line_enable) == '0) else $error("transmitter on during loop");
endmodule

bind lml_maint_ctrl lml_maint_chk #(.NUM_LINES(NUM_LINES), .STATUS_W(STATUS_W)) u_chk (
  .ref_clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .sys_init, .branch_a_taken,
  .branch_b_taken, .modem_status_in, .modem_status_out, .tx_line_enable, .rx_line_enable,
  .maint_clk_pulse, .line_aux_bit, .line_mode);

// ==== tb_top.sv ====
/*
  Self-checking bench for the line maintenance and loopback block.
  Assumes the checker file is compiled beside it; ce is held high except during t_ce.
*/
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lml_pkg::*;

  logic              ref_clk, rst, ce, wr_stb, rd_stb, irq, sys_init;
  logic              branch_a_taken, branch_b_taken;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata, rdata, line_tx_out, line_rx_pin, modem_enabled;
  logic [15:0]       status_transition, receiver_in, tx_line_enable, rx_line_enable;
  logic [15:0]       dsb_remote_enable, maint_clk_pulse, line_aux_bit;
  logic [3:0]        line_select;
  logic [63:0]       modem_status_in, modem_status_out;
  logic [31:0]       line_mode;
  int                n_errors, comparisons;

  lml_maint_ctrl DUT (.ref_clk, .rst, .ce, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .irq,
    .sys_init, .branch_a_taken, .branch_b_taken, .line_select, .line_tx_out, .line_rx_pin,
    .modem_enabled, .modem_status_in, .status_transition, .modem_status_out, .receiver_in,
    .tx_line_enable, .rx_line_enable, .dsb_remote_enable, .maint_clk_pulse, .line_aux_bit,
    .line_mode);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
  endtask

  task automatic t_reset_branch();
    rd(ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
    `CHK("lcr reset", 16'h0003, rdata)
    rd(3'h7);
    `CHK("unmapped", 16'h0000, rdata)
    branch_a_taken <= 1'b1;
    tick(2);
    rd(ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
    `CHK("branch a", 2'b10, rdata[1:0])
    branch_a_taken <= 1'b0;
    branch_b_taken <= 1'b1;
    tick(2);
    rd(ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
    `CHK("branch b", 2'b01, rdata[1:0])
    branch_b_taken <= 1'b0;
  endtask

  task automatic t_window();
    line_select <= 4'h5;
    for (int v = 0; v < 2; v++) begin
      line_tx_out <= 16'(v) << 5;
      tick(3);
      rd(ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
      `CHK("window tx", v[0], rdata[7])
    end
  endtask

  task automatic t_sync();
    line_select <= 4'h6;
    wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'hEA00);
    tick(2);
    `CHK("group mode", 32'h0000_5500, line_mode)
    `CHK("line bit", 16'h0040, line_aux_bit)
    `CHK("tx enable", 16'hFF0F, tx_line_enable)
    `CHK("sim rx", 4'hF, receiver_in[7:4])
    rd(ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
    `CHK("window data", 1'b1, rdata[7])
    `CHK("lcr upper", 8'h00, rdata[15:8])
    wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'hAA00);
    tick(2);
    `CHK("sim rx low", 4'h0, receiver_in[7:4])
    line_rx_pin <= 16'h0040;
    wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'h8200);
    tick(4);
    rd(ADDR_LINE_CONTROL_SYNC_MAINTENANCE);
    `CHK("window pin", 1'b1, rdata[7])
    line_select <= 4'hC;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'h8000 | (16'(m) << 11));
      tick(2);
      `CHK("mode code", {4{m[1:0]}}, line_mode[31:24])
    end
  endtask

  task automatic t_pulse();
    line_select <= 4'h6;
    wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'h8800);
    wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'h0100);
    tick(0);
    `CHK("pulse on", 16'h00F0, maint_clk_pulse)
    tick(1);
    `CHK("pulse off", 16'h0000, maint_clk_pulse)
  endtask

  // A pulse write while ce is low must leave no trace
  task automatic t_ce();
    ce <= 1'b0;
    wr(ADDR_LINE_CONTROL_SYNC_MAINTENANCE, 16'h0100);
    tick(0);
    `CHK("ce frozen pulse", 16'h0000, maint_clk_pulse)
    ce <= 1'b1;
    tick(2);
    `CHK("ce after pulse", 16'h0000, maint_clk_pulse)
  endtask

  task automatic t_async();
    line_tx_out <= 16'h0008;
    line_select <= 4'h3;
    wr(ADDR_LINE_CONTROL_ASYNC_MAINTENANCE, 16'h8E00);
    tick(2);
    `CHK("loop off", 3'b000, {tx_line_enable[3], rx_line_enable[3], dsb_remote_enable[3]})
    `CHK("loop rx", 1'b1, receiver_in[3])
    line_select <= 4'h2;
    wr(ADDR_LINE_CONTROL_ASYNC_MAINTENANCE, 16'h8800);
    tick(2);
    `CHK("no code", 1'b1, rx_line_enable[2])
    line_select <= 4'h3;
    wr(ADDR_LINE_CONTROL_ASYNC_MAINTENANCE, 16'h8600);
    tick(2);
    `CHK("loop clear", 1'b1, rx_line_enable[3])
  endtask

  task automatic t_init();
    modem_enabled   <= 16'h00FF;
    modem_status_in <= 64'h0123_4567_89AB_CDEF;
    wr(ADDR_SCAN_CSR, 16'h0200);
    tick(2);
    `CHK("forced", 64'h0123_4567_FFFF_FFFF, modem_status_out)
    sys_init <= 1'b1;
    tick(3);
    sys_init <= 1'b0;
    `CHK("init mode", 32'h0, line_mode)
    `CHK("init force", 64'h0123_4567_89AB_CDEF, modem_status_out)
    wr(ADDR_SCAN_CSR, 16'h0200);
    wr(ADDR_SCAN_CSR, 16'h0800);
    rd(ADDR_SCAN_CSR);
    `CHK("clear scan", 16'h0000, rdata)
  endtask

  task automatic t_step();
    rd(ADDR_IRQ_STATUS);
    `CHK("irq strobes", 16'h000C, rdata)
    wr(ADDR_IRQ_MASK, 16'h000F);
    status_transition <= 16'h0002;
    wr(ADDR_SCAN_CSR, 16'h0100);
    tick(19);
    rd(ADDR_SCAN_CSR);
    `CHK("step early", 16'h0000, rdata)
    tick(4);
    rd(ADDR_SCAN_CSR);
    `CHK("step done", 16'h0081, rdata)
    `CHK("irq on", 1'b1, irq)
    rd(ADDR_IRQ_STATUS);
    `CHK("irq status", 16'h0003, rdata)
    `CHK("irq off", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 16'h0000);
    wr(ADDR_SCAN_CSR, 16'h0100);
    wr(ADDR_SCAN_CSR, 16'h0100);
    tick(30);
    rd(ADDR_SCAN_CSR);
    `CHK("step pending", 16'h0082, rdata)
    `CHK("irq masked", 1'b0, irq)
    rd(ADDR_IRQ_STATUS);
    `CHK("step status", 16'h0001, rdata)
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    {rst, ce} = 2'b11;
    {wr_stb, rd_stb, sys_init, branch_a_taken, branch_b_taken} = '0;
    addr = '0;
    wdata = '0;
    line_select = '0;
    {line_tx_out, line_rx_pin, modem_enabled, status_transition} = '0;
    modem_status_in = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    tick(2);
    t_reset_branch();
    t_window();
    t_sync();
    t_pulse();
    t_ce();
    t_async();
    t_init();
    t_step();
    print_verdict();
  end
endmodule
